// [hw/scfg_pkg.sv]
// Shared constants for the serial configuration port and its host end
package scfg_pkg;
    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int INSTR_BITS = 16;
    localparam int DATA_BITS = 8;
    localparam int ADDR_BITS = 13;
    localparam int RW_POS = 15;
    localparam int LEN1_POS = 14;
    localparam int LEN0_POS = 13;
    localparam logic RW_READ = 1'b1;
    localparam logic RW_WRITE = 1'b0;
    localparam logic [1:0] LEN_STREAM = 2'h3;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [12:0] ADDR_PORT_CFG = 13'h0000;
    localparam logic [12:0] ADDR_CHIP_IDENTIFICATION = 13'h0001;
    localparam logic [12:0] ADDR_CHAN_IDX = 13'h0005;
    localparam logic [12:0] ADDR_COMMIT = 13'h00ff;
    localparam logic [12:0] ADDR_CONV_LO = 13'h0008;
    localparam logic [12:0] ADDR_CONV_HI = 13'h0025;
    localparam logic [12:0] ADDR_DIG_LO = 13'h003a;
    localparam logic [12:0] ADDR_DIG_HI = 13'h003e;
    localparam int SHADOW_WORDS = 55;
    localparam logic [7:0] PORT_CFG_RST = 8'h18;
    localparam logic [7:0] CHAN_IDX_RST = 8'hcf;
    localparam logic [7:0] COMMIT_RST = 8'h00;
    localparam logic [7:0] CHAN_ALL = 8'h0f;
    localparam int CFG_LSB_FIRST_HI = 6;
    localparam int CFG_LSB_FIRST_LO = 1;
    localparam int COMMIT_BIT = 0;
    localparam int NUM_CHAN = 4;
    // Identity value is arbitrary
    localparam logic [7:0] CHIP_IDENTIFICATION_VAL = 8'h5a;
    // Host link clock half period in system clocks
    localparam int HOST_HALF_PER = 4;
endpackage

// [hw/scfg_if.sv]
// Three-wire link between the serial host and the configuration port
`timescale 1ns/100ps
interface scfg_if;
    logic sclk;
    logic cs_n;
    logic sdio_host_o;
    logic sdio_host_oe;
    logic sdio_dev_o;
    logic sdio_dev_oe;
    logic sdio;
    // Wire level: pulled high when nobody drives
    assign sdio = sdio_host_oe ? sdio_host_o : (sdio_dev_oe ? sdio_dev_o : 1'b1);
    modport host (output sclk, output cs_n, output sdio_host_o, output sdio_host_oe, input sdio);
    modport dev (input sclk, input cs_n, output sdio_dev_o, output sdio_dev_oe, input sdio);
endinterface

// [hw/scfg_dev.sv]
// Device end: serial configuration port with shadowed, per-channel registers
`timescale 1ns/100ps
module scfg_dev (
    // System
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Link
    scfg_if.dev lnk,
    // Active register contents, channel copies packed channel 0 lowest
    output logic [8*scfg_pkg::SHADOW_WORDS-1:0] global_active_o,
    output logic [8*scfg_pkg::SHADOW_WORDS*scfg_pkg::NUM_CHAN-1:0] local_active_o,
    output logic commit_pulse_o,
    output logic busy_o
);
    localparam int NW = scfg_pkg::SHADOW_WORDS;
    localparam int NC = scfg_pkg::NUM_CHAN;

    // ------------------------------------------------------------
    // Input synchronisers and edge detect
    // ------------------------------------------------------------
    logic [2:0] sclk_s_r, cs_s_r;
    logic [1:0] sdi_s_r;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_s_r <= 3'h0;
            cs_s_r <= 3'h7;
            sdi_s_r <= 2'h0;
        end else begin
            sclk_s_r <= {sclk_s_r[1:0], lnk.sclk};
            cs_s_r <= {cs_s_r[1:0], lnk.cs_n};
            sdi_s_r <= {sdi_s_r[0], lnk.sdio};
        end
    end
    wire cs_act = !cs_s_r[1];
    wire sclk_rise = cs_act && sclk_s_r[1] && !sclk_s_r[2];
    wire sclk_fall = cs_act && !sclk_s_r[1] && sclk_s_r[2];
    wire cs_fall = cs_s_r[2] && !cs_s_r[1];

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] port_cfg_r, chan_idx_r, commit_r;
    logic [7:0] gshadow_r [NW];
    logic [7:0] lshadow_r [NC][NW];
    wire lsb_first = port_cfg_r[scfg_pkg::CFG_LSB_FIRST_HI];

    // Shadowed word index; returns NW when address is not shadowed
    function automatic int shadow_idx(input logic [12:0] a);
        if (a >= scfg_pkg::ADDR_CONV_LO && a <= scfg_pkg::ADDR_CONV_HI)
            return int'(a - scfg_pkg::ADDR_CONV_LO);
        if (a >= scfg_pkg::ADDR_DIG_LO && a <= scfg_pkg::ADDR_DIG_HI)
            return int'(a - scfg_pkg::ADDR_DIG_LO) + int'(scfg_pkg::ADDR_CONV_HI - scfg_pkg::ADDR_CONV_LO) + 1;
        return NW;
    endfunction

    // ------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------
    typedef enum {SCFG_IDLE, SCFG_INSTR, SCFG_DATA} scfg_state_t;
    scfg_state_t state_r;
    logic [4:0] bitcnt_r;
    logic [15:0] instr_r;
    logic [7:0] sh_r;
    logic [7:0] rd_r;
    logic [1:0] bytes_r;
    logic is_read_r;
    logic [12:0] addr_r;
    logic wr_pend_r;
    logic [12:0] wr_addr_r;
    logic [7:0] wr_data_r;
    logic done_r;

    wire [15:0] instr_nxt = lsb_first ? {sdi_s_r[1], instr_r[15:1]} : {instr_r[14:0], sdi_s_r[1]};
    wire [7:0] sh_nxt = lsb_first ? {sdi_s_r[1], sh_r[7:1]} : {sh_r[6:0], sdi_s_r[1]};

    // Read value mux; local reads take the lowest selected channel
    function automatic logic [7:0] read_val(input logic [12:0] a);
        int k;
        k = shadow_idx(a);
        if (a == scfg_pkg::ADDR_PORT_CFG) return port_cfg_r;
        if (a == scfg_pkg::ADDR_CHIP_IDENTIFICATION) return scfg_pkg::CHIP_IDENTIFICATION_VAL;
        if (a == scfg_pkg::ADDR_CHAN_IDX) return chan_idx_r;
        if (a == scfg_pkg::ADDR_COMMIT) return commit_r;
        if (k == NW) return 8'h00;
        for (int c = 0; c < NC; c++) begin
            if (chan_idx_r[c]) return lshadow_r[c][k];
        end
        return gshadow_r[k];
    endfunction

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= SCFG_IDLE;
            bitcnt_r <= 5'h00;
            instr_r <= 16'h0000;
            sh_r <= 8'h00;
            rd_r <= 8'h00;
            bytes_r <= 2'h0;
            is_read_r <= 1'b0;
            addr_r <= 13'h0000;
            wr_pend_r <= 1'b0;
            wr_addr_r <= 13'h0000;
            wr_data_r <= 8'h00;
            done_r <= 1'b0;
        end else begin
            wr_pend_r <= 1'b0;
            // stall keeps position unless a fresh frame begins after completion
            if (cs_fall && (state_r == SCFG_IDLE || done_r)) begin
                state_r <= SCFG_INSTR;
                bitcnt_r <= 5'h00;
                done_r <= 1'b0;
            end else if (sclk_rise) begin
                unique case (state_r)
                    SCFG_IDLE: ;
                    SCFG_INSTR: begin
                        instr_r <= instr_nxt;
                        if (bitcnt_r == 5'(scfg_pkg::INSTR_BITS - 1)) begin
                            state_r <= SCFG_DATA;
                            bitcnt_r <= 5'h00;
                            is_read_r <= instr_nxt[scfg_pkg::RW_POS] == scfg_pkg::RW_READ;
                            bytes_r <= instr_nxt[scfg_pkg::LEN1_POS:scfg_pkg::LEN0_POS];
                            addr_r <= instr_nxt[scfg_pkg::ADDR_BITS-1:0];
                            rd_r <= read_val(instr_nxt[scfg_pkg::ADDR_BITS-1:0]);
                        end else begin
                            bitcnt_r <= bitcnt_r + 5'h01;
                        end
                    end
                    SCFG_DATA: begin
                        sh_r <= sh_nxt;
                        if (bitcnt_r == 5'(scfg_pkg::DATA_BITS - 1)) begin
                            bitcnt_r <= 5'h00;
                            wr_pend_r <= !is_read_r;
                            wr_addr_r <= addr_r;
                            wr_data_r <= sh_nxt;
                            // Streaming walks the address downward
                            addr_r <= addr_r - 13'h0001;
                            rd_r <= read_val(addr_r - 13'h0001);
                            if (bytes_r == 2'h0) begin
                                state_r <= SCFG_IDLE;
                                done_r <= 1'b1;
                            end else if (bytes_r != scfg_pkg::LEN_STREAM) begin
                                bytes_r <= bytes_r - 2'h1;
                            end
                        end else begin
                            bitcnt_r <= bitcnt_r + 5'h01;
                        end
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Read data driver, launched on falling serial clock
    // ------------------------------------------------------------
    logic sdo_r, sdo_oe_r;
    wire [2:0] bsel = lsb_first ? bitcnt_r[2:0] : 3'(7 - int'(bitcnt_r[2:0]));
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sdo_r <= 1'b0;
            sdo_oe_r <= 1'b0;
        end else if (!cs_act) begin
            sdo_oe_r <= 1'b0;
        end else if (sclk_fall) begin
            sdo_oe_r <= state_r == SCFG_DATA && is_read_r;
            sdo_r <= rd_r[bsel];
        end
    end
    assign lnk.sdio_dev_o = sdo_r;
    assign lnk.sdio_dev_oe = sdo_oe_r;

    // ------------------------------------------------------------
    // Register writes and commit
    // ------------------------------------------------------------
    int widx;
    assign widx = shadow_idx(wr_addr_r);
    wire lsb_wr = wr_data_r[scfg_pkg::CFG_LSB_FIRST_HI] | wr_data_r[scfg_pkg::CFG_LSB_FIRST_LO];
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_cfg_r <= scfg_pkg::PORT_CFG_RST;
            chan_idx_r <= scfg_pkg::CHAN_IDX_RST;
            commit_r <= scfg_pkg::COMMIT_RST;
            for (int i = 0; i < NW; i++) begin
                gshadow_r[i] <= 8'h00;
                for (int c = 0; c < NC; c++) lshadow_r[c][i] <= 8'h00;
            end
        end else begin
            if (commit_r[scfg_pkg::COMMIT_BIT]) commit_r <= scfg_pkg::COMMIT_RST;
            if (wr_pend_r) begin
                unique case (wr_addr_r)
                    scfg_pkg::ADDR_PORT_CFG: begin
                        if ((chan_idx_r & scfg_pkg::CHAN_ALL) == scfg_pkg::CHAN_ALL)
                            // Nibbles mirrored so either order sets the mode
                            port_cfg_r <= {1'b0, lsb_wr, 1'b0, 2'h3, 1'b0,
                                           lsb_wr, 1'b0};
                    end
                    scfg_pkg::ADDR_CHAN_IDX: chan_idx_r <= wr_data_r;
                    scfg_pkg::ADDR_COMMIT: commit_r <= wr_data_r & 8'h01;
                    default: begin
                        if (widx != NW) begin
                            gshadow_r[widx] <= wr_data_r;
                            for (int c = 0; c < NC; c++) begin
                                if (chan_idx_r[c]) lshadow_r[c][widx] <= wr_data_r;
                            end
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            global_active_o <= '0;
            local_active_o <= '0;
            commit_pulse_o <= 1'b0;
        end else begin
            commit_pulse_o <= commit_r[scfg_pkg::COMMIT_BIT];
            if (commit_r[scfg_pkg::COMMIT_BIT]) begin
                for (int i = 0; i < NW; i++) begin
                    global_active_o[8*i +: 8] <= gshadow_r[i];
                    for (int c = 0; c < NC; c++)
                        local_active_o[8*(c*NW+i) +: 8] <= lshadow_r[c][i];
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) busy_o <= 1'b0;
        else busy_o <= state_r != SCFG_IDLE;
    end
endmodule

// [hw/scfg_host.sv]
// Host end: serial master issuing single register reads and writes
`timescale 1ns/100ps
module scfg_host (
    // System
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Link
    scfg_if.host lnk,
    // Request
    input wire logic req_i,
    input wire logic req_read_i,
    input wire logic [12:0] req_addr_i,
    input wire logic [7:0] req_wdata_i,
    input wire logic lsb_first_i,
    // Answer
    output logic ready_o,
    output logic done_o,
    output logic [7:0] rdata_o
);
    // ------------------------------------------------------------
    // Frame engine, one byte per frame, clock made by a divider
    // ------------------------------------------------------------
    typedef enum {SCFGH_IDLE, SCFGH_RUN, SCFGH_END} scfgh_state_t;
    scfgh_state_t state_r;
    logic [23:0] frame_r;
    logic [4:0] bit_r;
    logic [2:0] div_r;
    logic sclk_r, cs_n_r, sdo_r, oe_r, rd_r;
    logic [1:0] sdi_s_r;
    logic [7:0] rx_r;

    function automatic logic [15:0] mk_instr(input logic rd, input logic [12:0] a);
        return {rd ? scfg_pkg::RW_READ : scfg_pkg::RW_WRITE, 2'h0, a};
    endfunction

    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) r[i] = v[7 - i];
        return r;
    endfunction

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) sdi_s_r <= 2'h0;
        else sdi_s_r <= {sdi_s_r[0], lnk.sdio};
    end

    wire [23:0] word = {mk_instr(req_read_i, req_addr_i), req_wdata_i};
    // Instruction and data byte are each reversed on their own, so the instruction still leads
    wire [23:0] frame_nxt = lsb_first_i ? {rev8(word[15:8]), rev8(word[23:16]), rev8(word[7:0])} : word;
    wire [7:0] rx_last = {rx_r[6:0], sdi_s_r[1]};
    wire [4:0] idx = 5'(23 - int'(bit_r));
    wire tick = div_r == 3'(scfg_pkg::HOST_HALF_PER - 1);

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= SCFGH_IDLE;
            frame_r <= 24'h000000;
            bit_r <= 5'h00;
            div_r <= 3'h0;
            sclk_r <= 1'b0;
            cs_n_r <= 1'b1;
            sdo_r <= 1'b0;
            oe_r <= 1'b0;
            rd_r <= 1'b0;
            rx_r <= 8'h00;
            ready_o <= 1'b0;
            done_o <= 1'b0;
            rdata_o <= 8'h00;
        end else begin
            done_o <= 1'b0;
            div_r <= tick ? 3'h0 : div_r + 3'h1;
            unique case (state_r)
                SCFGH_IDLE: begin
                    ready_o <= 1'b1;
                    if (req_i) begin
                        // host matches the device bit order
                        frame_r <= frame_nxt;
                        // First bit settles before the first clock rise
                        sdo_r <= frame_nxt[23];
                        rd_r <= req_read_i;
                        bit_r <= 5'h00;
                        ready_o <= 1'b0;
                        cs_n_r <= 1'b0;
                        oe_r <= 1'b1;
                        sclk_r <= 1'b0;
                        div_r <= 3'h0;
                        state_r <= SCFGH_RUN;
                    end
                end
                SCFGH_RUN: if (tick) begin
                    sclk_r <= !sclk_r;
                    if (!sclk_r) begin
                        if (bit_r == 5'd23) state_r <= SCFGH_END;
                        bit_r <= bit_r + 5'h01;
                    end else begin
                        // Taken on the fall: device launch plus both synchronisers exceed a half period
                        if (bit_r >= 5'd17) rx_r <= rx_last;
                        oe_r <= !(rd_r && bit_r >= 5'd16);
                    end
                    sdo_r <= frame_r[idx];
                end
                SCFGH_END: if (tick) begin
                    // Select stays high a half period so the device lets go of the pin first
                    if (!cs_n_r) begin
                        cs_n_r <= 1'b1;
                        oe_r <= 1'b0;
                        sclk_r <= 1'b0;
                        done_o <= 1'b1;
                        rdata_o <= lsb_first_i ? rev8(rx_last) : rx_last;
                    end else begin
                        state_r <= SCFGH_IDLE;
                    end
                end
            endcase
        end
    end
    assign lnk.sclk = sclk_r;
    assign lnk.cs_n = cs_n_r;
    assign lnk.sdio_host_o = sdo_r;
    assign lnk.sdio_host_oe = oe_r;
endmodule

// [dv/scfg_link_sva.sv]
// Link checker for the three-wire configuration port
`timescale 1ns/100ps
module scfg_link_sva (
    // System
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdio_host_o,
    input wire logic sdio_host_oe,
    input wire logic sdio_dev_o,
    input wire logic sdio_dev_oe,
    input wire logic sdio
);
    // ------------------------------------------------------------
    // Helper: serial clock rises counted within a frame
    // ------------------------------------------------------------
    logic sclk_q;
    logic [5:0] rise_cnt;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) sclk_q <= 1'b0;
        else sclk_q <= sclk;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) rise_cnt <= 6'h00;
        else if (cs_n) rise_cnt <= 6'h00;
        else if (sclk && !sclk_q) rise_cnt <= rise_cnt + 6'h01;
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    a_release_when_idle: assert property (cs_n [*5] |-> !sdio_dev_oe)
        else $error("device still drives data with select high");
    a_no_contention: assert property (!(sdio_host_oe && sdio_dev_oe))
        else $error("both ends drive the data pin");
    a_host_quiet_idle: assert property (cs_n && $past(cs_n) |-> !sdio_host_oe)
        else $error("host drives data outside a frame");
    a_clock_idle_low: assert property (cs_n && $past(cs_n) |-> !sclk)
        else $error("serial clock moves outside a frame");
    a_turnaround_point: assert property ($rose(sdio_dev_oe) |-> rise_cnt inside {6'h10, 6'h11})
        else $error("device turned the pin around off the instruction end");
    a_frame_bit_count: assert property ($rose(cs_n) |-> rise_cnt == 6'h18)
        else $error("frame did not carry instruction plus one byte");
    a_dev_bit_timing: assert property (sdio_dev_oe && $changed(sdio_dev_o) |-> !sclk)
        else $error("read bit changed while serial clock high");
    a_host_bit_timing: assert property (sdio_host_oe && $changed(sdio_host_o) |-> !sclk)
        else $error("write bit changed while serial clock high");
    a_read_on_pin: assert property (sdio_dev_oe && !sdio_host_oe |-> sdio == sdio_dev_o)
        else $error("read bit does not reach the data pin");
endmodule

// [dv/scfg_test.sv]
// Self-checking bench: host and device ends joined over the link
`timescale 1ns/100ps
module scfg_test;
    logic sys_clk_i;
    logic rst_n_i;
    logic req_i;
    logic req_read_i;
    logic [12:0] req_addr_i;
    logic [7:0] req_wdata_i;
    logic lsb_first_i;
    logic ready_o;
    logic done_o;
    logic [7:0] rdata_o;
    logic [8*scfg_pkg::SHADOW_WORDS-1:0] global_active_o;
    logic [8*scfg_pkg::SHADOW_WORDS*scfg_pkg::NUM_CHAN-1:0] local_active_o;
    logic commit_pulse_o;
    logic busy_o;
    int fails = 0;
    int check_count = 0;
    int commits = 0;

    scfg_if lnk();
    scfg_dev u_scfg_dev (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .lnk(lnk),
        .global_active_o(global_active_o), .local_active_o(local_active_o),
        .commit_pulse_o(commit_pulse_o), .busy_o(busy_o));
    scfg_host u_scfg_host (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .lnk(lnk), .req_i(req_i),
        .req_read_i(req_read_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
        .lsb_first_i(lsb_first_i), .ready_o(ready_o), .done_o(done_o), .rdata_o(rdata_o));
    scfg_link_sva u_scfg_link_sva (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sclk(lnk.sclk),
        .cs_n(lnk.cs_n), .sdio_host_o(lnk.sdio_host_o), .sdio_host_oe(lnk.sdio_host_oe),
        .sdio_dev_o(lnk.sdio_dev_o), .sdio_dev_oe(lnk.sdio_dev_oe), .sdio(lnk.sdio));

    // ------------------------------------------------------------
    // Clock, commit counter, watchdog
    // ------------------------------------------------------------
    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end

    always @(posedge sys_clk_i) begin
        if (commit_pulse_o === 1'b1) commits++;
    end

    // About 30 frames of some 200 clocks each, with ample margin
    initial begin
        #(30000 * 100);
        fails++;
        $display("unexpected at %0t: watchdog expired", $time);
        finish_test();
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Entered just after a clock edge; request held until the edge that takes it
    task automatic access(input logic rd, input logic [12:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        while (ready_o !== 1'b1 && n < 50) begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        req_read_i = rd;
        req_addr_i = a;
        req_wdata_i = d;
        req_i = 1'b1;
        @(posedge sys_clk_i);
        #1;
        req_i = 1'b0;
        n = 0;
        while (done_o !== 1'b1 && n < 400) begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        if (n >= 400) begin
            fails++;
            $display("unexpected at %0t: no completion", $time);
        end
        q = rdata_o;
    endtask

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [7:0] q;
        access(scfg_pkg::RW_WRITE, a, d, q);
    endtask

    task automatic rd_chk(input logic [12:0] a, input logic [7:0] exp);
        logic [7:0] q;
        access(scfg_pkg::RW_READ, a, 8'h00, q);
        check_byte(q, exp);
    endtask

    function automatic logic [7:0] lw(input int c, input int i);
        return local_active_o[8*(c*scfg_pkg::SHADOW_WORDS+i) +: 8];
    endfunction

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n_i = 1'b0;
        req_i = 1'b0;
        req_read_i = 1'b0;
        req_addr_i = 13'h0000;
        req_wdata_i = 8'h00;
        lsb_first_i = 1'b0;
        repeat (10) @(posedge sys_clk_i);
        #1;
        rst_n_i = 1'b1;
        @(posedge sys_clk_i);
        #1;

        rd_chk(scfg_pkg::ADDR_PORT_CFG, scfg_pkg::PORT_CFG_RST);
        rd_chk(scfg_pkg::ADDR_CHIP_IDENTIFICATION, scfg_pkg::CHIP_IDENTIFICATION_VAL);
        rd_chk(scfg_pkg::ADDR_CHAN_IDX, scfg_pkg::CHAN_IDX_RST);
        rd_chk(scfg_pkg::ADDR_COMMIT, scfg_pkg::COMMIT_RST);
        $display("test defaults done");

        // Two channels selected, low and high ends of the shadowed range
        wr(scfg_pkg::ADDR_CHAN_IDX, 8'h03);
        wr(scfg_pkg::ADDR_CONV_LO, 8'ha5);
        wr(scfg_pkg::ADDR_DIG_HI, 8'h3c);
        repeat (10) @(posedge sys_clk_i);
        #1;
        check_byte(lw(0, 0), 8'h00);
        check_byte(global_active_o[7:0], 8'h00);
        check_byte(8'(commits), 8'h00);
        wr(scfg_pkg::ADDR_COMMIT, 8'h01);
        repeat (10) @(posedge sys_clk_i);
        #1;
        check_byte(8'(commits), 8'h01);
        check_byte(global_active_o[7:0], 8'ha5);
        check_byte(8'(busy_o), 8'h00);
        check_byte(lw(0, 0), 8'ha5);
        check_byte(lw(1, 0), 8'ha5);
        check_byte(lw(2, 0), 8'h00);
        check_byte(lw(0, 34), 8'h3c);
        check_byte(lw(1, 34), 8'h3c);
        rd_chk(scfg_pkg::ADDR_COMMIT, 8'h00);
        $display("test shadow commit done");

        // Different values per channel, then a read with two selected
        wr(scfg_pkg::ADDR_CHAN_IDX, 8'h02);
        wr(13'h0009, 8'h22);
        wr(scfg_pkg::ADDR_CHAN_IDX, 8'h01);
        wr(13'h0009, 8'h11);
        wr(scfg_pkg::ADDR_CHAN_IDX, 8'h03);
        rd_chk(13'h0009, 8'h11);
        wr(scfg_pkg::ADDR_CHAN_IDX, 8'h02);
        rd_chk(13'h0009, 8'h22);
        check_byte(8'(commits), 8'h01);
        $display("test channel copies done");

        // Port configuration needs every channel selected
        wr(scfg_pkg::ADDR_CHAN_IDX, 8'h04);
        rd_chk(scfg_pkg::ADDR_CHIP_IDENTIFICATION, scfg_pkg::CHIP_IDENTIFICATION_VAL);
        wr(scfg_pkg::ADDR_PORT_CFG, 8'h5a);
        rd_chk(scfg_pkg::ADDR_PORT_CFG, scfg_pkg::PORT_CFG_RST);
        wr(scfg_pkg::ADDR_CHAN_IDX, 8'h0f);
        wr(scfg_pkg::ADDR_PORT_CFG, 8'h5a);
        lsb_first_i = 1'b1;
        rd_chk(scfg_pkg::ADDR_PORT_CFG, 8'h5a);
        rd_chk(scfg_pkg::ADDR_CHIP_IDENTIFICATION, scfg_pkg::CHIP_IDENTIFICATION_VAL);
        rd_chk(scfg_pkg::ADDR_CHAN_IDX, 8'h0f);
        wr(scfg_pkg::ADDR_PORT_CFG, scfg_pkg::PORT_CFG_RST);
        lsb_first_i = 1'b0;
        rd_chk(scfg_pkg::ADDR_PORT_CFG, scfg_pkg::PORT_CFG_RST);
        $display("test bit order done");

        finish_test();
    end
endmodule
